// >>> src/mscnt_defines.svh
`ifndef MSCNT_DEFINES_SVH
`define MSCNT_DEFINES_SVH

// Counter and frame length widths
`define MSCNT_FRM_W 20
`define MSCNT_BYT_W 32
`define MSCNT_LEN_W 14
// Receive size bucket bounds (bytes)
`define MSCNT_SZ_512  14'h0200
`define MSCNT_SZ_1023 14'h03ff
`define MSCNT_SZ_1024 14'h0400
`define MSCNT_SZ_1518 14'h05ee
// Transmit size bucket bounds (bytes)
`define MSCNT_SZ_64  14'h0040
`define MSCNT_SZ_65  14'h0041
`define MSCNT_SZ_127 14'h007f
`define MSCNT_SZ_128 14'h0080
`define MSCNT_SZ_255 14'h00ff
`define MSCNT_SZ_256 14'h0100
`define MSCNT_SZ_511 14'h01ff
// Deferral margin in bytes and the shift (log2) for bit times per byte
`define MSCNT_DEFER_MARGIN 14'h0010
`define MSCNT_BITS_PER_BYTE 3
// Collision count that makes a frame excessive
`define MSCNT_EXCESS_COLL 5'h10
// One microsecond in ns and the clock period in ns
`define MSCNT_US_NS 1000
`define MSCNT_CLK_NS 8
`define MSCNT_US_CYC (`MSCNT_US_NS / `MSCNT_CLK_NS)
`define MSCNT_US_CW 7

`endif

// >>> src/mscnt_pkg.sv
package mscnt_pkg;
    `include "mscnt_defines.svh"

    // Frame cast type
    typedef enum logic [1:0] {
        MSCNT_UCAST = 2'h0,
        MSCNT_BCAST = 2'h1,
        MSCNT_MCAST = 2'h2
    } mscnt_cast_type;

    // Receive frame completion report
    typedef struct packed {
        logic                    done;
        logic                    good;
        logic                    filt_fail;
        logic                    fifo_ovf;
        logic [`MSCNT_LEN_W-1:0] len;
    } mscnt_rx_type;

    // Transmit frame completion report
    typedef struct packed {
        logic                    done;
        logic                    good;
        logic                    fcs_err;
        logic                    carrier_err;
        logic                    late_coll;
        logic                    flow_ctrl;
        logic                    pause;
        logic                    partial;
        logic [4:0]              coll_cnt;
        mscnt_cast_type          cast;
        logic [`MSCNT_LEN_W-1:0] len;
    } mscnt_tx_type;

    // Receive counters
    typedef struct packed {
        logic [`MSCNT_FRM_W-1:0] rx_512_1023;
        logic [`MSCNT_FRM_W-1:0] rx_1024_1518;
        logic [`MSCNT_FRM_W-1:0] rx_over_1518;
        logic [`MSCNT_BYT_W-1:0] rx_lpi_trans;
        logic [`MSCNT_BYT_W-1:0] rx_lpi_time;
    } mscnt_rxc_type;

    // Transmit counters
    typedef struct packed {
        logic [`MSCNT_FRM_W-1:0] fcs_err;
        logic [`MSCNT_FRM_W-1:0] excess_defer;
        logic [`MSCNT_FRM_W-1:0] carrier_err;
        logic [`MSCNT_BYT_W-1:0] bad_bytes;
        logic [`MSCNT_FRM_W-1:0] single_coll;
        logic [`MSCNT_FRM_W-1:0] multi_coll;
        logic [`MSCNT_FRM_W-1:0] excess_coll;
        logic [`MSCNT_FRM_W-1:0] late_coll;
        logic [`MSCNT_BYT_W-1:0] ucast_bytes;
        logic [`MSCNT_BYT_W-1:0] bcast_bytes;
        logic [`MSCNT_BYT_W-1:0] mcast_bytes;
        logic [`MSCNT_FRM_W-1:0] ucast_frm;
        logic [`MSCNT_FRM_W-1:0] bcast_frm;
        logic [`MSCNT_FRM_W-1:0] mcast_frm;
        logic [`MSCNT_FRM_W-1:0] pause_frm;
        logic [`MSCNT_FRM_W-1:0] sz_64;
        logic [`MSCNT_FRM_W-1:0] sz_65_127;
        logic [`MSCNT_FRM_W-1:0] sz_128_255;
        logic [`MSCNT_FRM_W-1:0] sz_256_511;
    } mscnt_txc_type;
endpackage

// >>> src/mscnt_stats.sv
// Behaviour
// R1: Count good receive frames 512-1023, 1024-1518, larger
// R2: Skip filtered or overflow-dropped receive frames
// R3: Count receive idle indication rising edges
// R4: Accumulate receive idle time in microseconds
// R5: Idle counters held clear while enable low
// R6: Idle counters run in all listed power states
// R7: Count transmit frames with bad check sequence
// R8: Count frames deferred past two max frames+16
// R9: Deferral timer restarts on each new deferral
// R10: Count transmit frames with carrier sense error
// R11: Accumulate bytes of errored transmissions
// R12: Count single and multiple collision successes
// R13: Count frames aborted at sixteen collisions
// R14: Count frames aborted by late collision
// R15: Accumulate good cast-type bytes, no flow control
// R16: Count good cast-type frames, no flow control
// R17: Count successfully transmitted pause frames
// R18: Count good transmit frames in small buckets
// R19: Receive byte counts omit stripped tag, FCS
// R20: Count once at completion, wrap at maximum
`timescale 1ns/1ns
`include "mscnt_defines.svh"
module mscnt_stats
    import mscnt_pkg::*;
(
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst,
    // Control bits
    input  wire logic                    energy_efficient_enable,
    input  wire logic                    sleep_state_zero,
    input  wire logic                    sleep_state_three,
    input  wire logic [`MSCNT_LEN_W-1:0] max_frame_size,
    // Receive and transmit frame events
    input  wire mscnt_rx_type            rx_evt,
    input  wire mscnt_tx_type            tx_evt,
    // Transmitter deferral state (1 while waiting to transmit)
    input  wire logic                    tx_deferring,
    input  wire logic                    tx_defer_start,
    // Idle indication from the PHY, asynchronous
    input  wire logic                    phy_rx_lpi,
    // Counter values
    output mscnt_rxc_type                rx_cnt,
    output mscnt_txc_type                tx_cnt
);

    // Frame counter increment, wraps at maximum
    function automatic logic [`MSCNT_FRM_W-1:0] inc_f(input logic [`MSCNT_FRM_W-1:0] v,
                                                       input logic en);
        inc_f = en ? v + `MSCNT_FRM_W'h1 : v; // R20
    endfunction

    // Byte counter accumulate, wraps at maximum
    function automatic logic [`MSCNT_BYT_W-1:0] add_b(input logic [`MSCNT_BYT_W-1:0] v,
                                                       input logic en,
                                                       input logic [`MSCNT_LEN_W-1:0] n);
        add_b = en ? v + {{(`MSCNT_BYT_W-`MSCNT_LEN_W){1'b0}}, n} : v; // R20
    endfunction

    // Inclusive range test on a frame length
    function automatic logic in_rng(input logic [`MSCNT_LEN_W-1:0] l,
                                    input logic [`MSCNT_LEN_W-1:0] lo,
                                    input logic [`MSCNT_LEN_W-1:0] hi);
        in_rng = (l >= lo) && (l <= hi);
    endfunction

    mscnt_rxc_type rx_ff;
    mscnt_rxc_type nxt_rx;
    mscnt_txc_type tx_ff;
    mscnt_txc_type nxt_tx;

    // Idle synchroniser; stage one is read only by stage two
    logic                     lpi_s1_ff;
    logic                     lpi_s2_ff;
    logic                     lpi_s3_ff;
    logic                     lpi_ff;
    logic [`MSCNT_US_CW-1:0]  us_ff;
    logic [`MSCNT_US_CW-1:0]  nxt_us;
    logic                     nxt_lpi;
    logic                     lpi_rise;
    logic                     us_tick;

    // Deferral timer in bit times
    logic [`MSCNT_BYT_W-1:0]  defer_ff;
    logic [`MSCNT_BYT_W-1:0]  nxt_defer;
    logic                     excess_ff;
    logic                     nxt_excess;
    logic [`MSCNT_BYT_W-1:0]  defer_limit;
    logic [`MSCNT_BYT_W-1:0]  max_frame_w;

    // Length arrives with any stripped tag and check sequence already removed
    wire [`MSCNT_LEN_W-1:0] rx_len = rx_evt.len; // R19

    // Receive bucket qualification
    wire rx_ok  = rx_evt.done && rx_evt.good && !rx_evt.filt_fail && !rx_evt.fifo_ovf; // R2
    wire rx_b1  = rx_ok && in_rng(rx_len, `MSCNT_SZ_512, `MSCNT_SZ_1023);  // R1
    wire rx_b2  = rx_ok && in_rng(rx_len, `MSCNT_SZ_1024, `MSCNT_SZ_1518); // R1
    wire rx_b3  = rx_ok && (rx_len > `MSCNT_SZ_1518);                      // R1

    // Idle level changes count once stages two and three agree
    assign nxt_lpi  = (lpi_s2_ff == lpi_s3_ff) ? lpi_s3_ff : lpi_ff;
    assign lpi_rise = nxt_lpi && !lpi_ff; // R3
    // The prescaler is free of power state; only the enable and a low idle level stop it
    assign us_tick  = lpi_ff && (us_ff == `MSCNT_US_CW'(`MSCNT_US_CYC - 1)); // R6
    assign nxt_us   = (!energy_efficient_enable || !lpi_ff || us_tick) ? '0
                      : us_ff + `MSCNT_US_CW'h1;

    // Receive counter next values
    always_comb begin
        nxt_rx              = rx_ff;
        nxt_rx.rx_512_1023  = inc_f(rx_ff.rx_512_1023, rx_b1);
        nxt_rx.rx_1024_1518 = inc_f(rx_ff.rx_1024_1518, rx_b2);
        nxt_rx.rx_over_1518 = inc_f(rx_ff.rx_over_1518, rx_b3);
        if (!energy_efficient_enable) begin
            nxt_rx.rx_lpi_trans = '0; // R5
            nxt_rx.rx_lpi_time  = '0; // R5
        end else begin
            nxt_rx.rx_lpi_trans = rx_ff.rx_lpi_trans + {31'h0, lpi_rise}; // R3
            nxt_rx.rx_lpi_time  = rx_ff.rx_lpi_time + {31'h0, us_tick};   // R4
        end
    end

    // Two max frames plus margin, in bit times
    // Widened before doubling so that jumbo sizes cannot wrap the limit
    assign max_frame_w = {{(`MSCNT_BYT_W-`MSCNT_LEN_W){1'b0}}, max_frame_size};
    assign defer_limit = ((max_frame_w << 1)
                          + {{(`MSCNT_BYT_W-`MSCNT_LEN_W){1'b0}}, `MSCNT_DEFER_MARGIN})
                         << `MSCNT_BITS_PER_BYTE; // R8
    // Timer restarts at each new deferral, never accumulates
    assign nxt_defer  = tx_defer_start ? '0                       // R9
                        : tx_deferring ? defer_ff + `MSCNT_BYT_W'h1 : defer_ff;
    // The completing frame spends the flag, so a later undeferred frame is not counted
    assign nxt_excess = tx_defer_start ? 1'b0
                        : ((excess_ff && !tx_evt.done)
                           || (tx_deferring && (defer_ff > defer_limit))); // R8

    // Transmit qualification
    wire tx_g   = tx_evt.done && tx_evt.good;
    wire tx_gnp = tx_g && !tx_evt.partial;
    wire tx_gf  = tx_gnp && !tx_evt.flow_ctrl;           // R15
    wire tx_err = tx_evt.done && !tx_evt.good;
    wire tx_u   = tx_gf && (tx_evt.cast == MSCNT_UCAST);
    wire tx_b   = tx_gf && (tx_evt.cast == MSCNT_BCAST);
    wire tx_m   = tx_gf && (tx_evt.cast == MSCNT_MCAST);
    wire tx_uf  = tx_g && !tx_evt.flow_ctrl && (tx_evt.cast == MSCNT_UCAST); // R16
    wire tx_bf  = tx_g && !tx_evt.flow_ctrl && (tx_evt.cast == MSCNT_BCAST); // R16
    wire tx_mf  = tx_g && !tx_evt.flow_ctrl && (tx_evt.cast == MSCNT_MCAST); // R16
    wire tx_ecl = tx_evt.done && (tx_evt.coll_cnt >= `MSCNT_EXCESS_COLL);    // R13

    // Transmit counter next values
    always_comb begin
        nxt_tx              = tx_ff;
        nxt_tx.fcs_err      = inc_f(tx_ff.fcs_err, tx_evt.done && tx_evt.fcs_err); // R7
        nxt_tx.excess_defer = inc_f(tx_ff.excess_defer, tx_evt.done && excess_ff); // R8
        nxt_tx.carrier_err  = inc_f(tx_ff.carrier_err,
                                    tx_evt.done && tx_evt.carrier_err);           // R10
        nxt_tx.bad_bytes    = add_b(tx_ff.bad_bytes, tx_err, tx_evt.len);         // R11
        nxt_tx.single_coll  = inc_f(tx_ff.single_coll,
                                    tx_g && (tx_evt.coll_cnt == 5'h01));          // R12
        nxt_tx.multi_coll   = inc_f(tx_ff.multi_coll,
                                    tx_g && (tx_evt.coll_cnt > 5'h01));           // R12
        nxt_tx.excess_coll  = inc_f(tx_ff.excess_coll, tx_ecl);                   // R13
        nxt_tx.late_coll    = inc_f(tx_ff.late_coll,
                                    tx_evt.done && tx_evt.late_coll);             // R14
        nxt_tx.ucast_bytes  = add_b(tx_ff.ucast_bytes, tx_u, tx_evt.len);         // R15
        nxt_tx.bcast_bytes  = add_b(tx_ff.bcast_bytes, tx_b, tx_evt.len);         // R15
        nxt_tx.mcast_bytes  = add_b(tx_ff.mcast_bytes, tx_m, tx_evt.len);         // R15
        nxt_tx.ucast_frm    = inc_f(tx_ff.ucast_frm, tx_uf);                      // R16
        nxt_tx.bcast_frm    = inc_f(tx_ff.bcast_frm, tx_bf);                      // R16
        nxt_tx.mcast_frm    = inc_f(tx_ff.mcast_frm, tx_mf);                      // R16
        nxt_tx.pause_frm    = inc_f(tx_ff.pause_frm, tx_g && tx_evt.pause);       // R17
        nxt_tx.sz_64        = inc_f(tx_ff.sz_64,
                                    tx_gf && (tx_evt.len == `MSCNT_SZ_64));       // R18
        nxt_tx.sz_65_127    = inc_f(tx_ff.sz_65_127,
                                    tx_gnp && in_rng(tx_evt.len, `MSCNT_SZ_65,
                                                     `MSCNT_SZ_127));             // R18
        nxt_tx.sz_128_255   = inc_f(tx_ff.sz_128_255,
                                    tx_gnp && in_rng(tx_evt.len, `MSCNT_SZ_128,
                                                     `MSCNT_SZ_255));             // R18
        nxt_tx.sz_256_511   = inc_f(tx_ff.sz_256_511,
                                    tx_gnp && in_rng(tx_evt.len, `MSCNT_SZ_256,
                                                     `MSCNT_SZ_511));             // R18
    end

    // Idle synchroniser and prescaler
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lpi_s1_ff <= 1'b0;
            lpi_s2_ff <= 1'b0;
            lpi_s3_ff <= 1'b0;
            lpi_ff    <= 1'b0;
            us_ff     <= '0;
        end else begin
            lpi_s1_ff <= phy_rx_lpi;
            lpi_s2_ff <= lpi_s1_ff;
            lpi_s3_ff <= lpi_s2_ff;
            lpi_ff    <= nxt_lpi;
            us_ff     <= nxt_us;
        end
    end

    // Deferral tracking
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            defer_ff  <= '0;
            excess_ff <= 1'b0;
        end else begin
            defer_ff  <= nxt_defer;
            excess_ff <= nxt_excess;
        end
    end

    // Counter banks
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_ff <= '0;
            tx_ff <= '0;
        end else begin
            rx_ff <= nxt_rx;
            tx_ff <= nxt_tx;
        end
    end

    assign rx_cnt = rx_ff;
    assign tx_cnt = tx_ff;

endmodule

// >>> tb/mscnt_stats_properties.sv
`timescale 1ns/1ns
`include "mscnt_defines.svh"
module mscnt_stats_chk
    import mscnt_pkg::*;
(
    // Clock and reset
    input wire logic                    mclk,
    input wire logic                    rst,
    // Controls and events
    input wire logic                    energy_efficient_enable,
    input wire logic                    sleep_state_zero,
    input wire logic                    sleep_state_three,
    input wire logic [`MSCNT_LEN_W-1:0] max_frame_size,
    input wire mscnt_rx_type            rx_evt,
    input wire mscnt_tx_type            tx_evt,
    input wire logic                    tx_deferring,
    input wire logic                    tx_defer_start,
    input wire logic                    phy_rx_lpi,
    // Counters
    input wire mscnt_rxc_type           rx_cnt,
    input wire mscnt_txc_type           tx_cnt
);
    // Qualified frame completions
    wire rx_ok = rx_evt.done && rx_evt.good && !rx_evt.filt_fail && !rx_evt.fifo_ovf;
    wire tx_ok = tx_evt.done && tx_evt.good;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    chk_rx_mid_bucket: assert property (
        rx_ok && rx_evt.len >= `MSCNT_SZ_512 && rx_evt.len <= `MSCNT_SZ_1023
        |=> rx_cnt.rx_512_1023 == $past(rx_cnt.rx_512_1023) + 20'h1)
        else $error("mid receive bucket missed");
    chk_rx_big_bucket: assert property (
        rx_ok && rx_evt.len > `MSCNT_SZ_1518
        |=> rx_cnt.rx_over_1518 == $past(rx_cnt.rx_over_1518) + 20'h1)
        else $error("large receive bucket missed");
    // Dropped frames must leave every bucket alone
    chk_rx_drop_skip: assert property (
        rx_evt.done && (rx_evt.filt_fail || rx_evt.fifo_ovf) |=> $stable(rx_cnt.rx_512_1023)
        && $stable(rx_cnt.rx_1024_1518) && $stable(rx_cnt.rx_over_1518))
        else $error("dropped receive frame counted");
    chk_lpi_held_clear: assert property (
        !energy_efficient_enable |=> rx_cnt.rx_lpi_trans == 32'h0 && rx_cnt.rx_lpi_time == 32'h0)
        else $error("idle counters not cleared");
    // Sync plus filter delay allowed for
    chk_lpi_edge_count: assert property (
        energy_efficient_enable && $rose(phy_rx_lpi) |-> ##[1:6] $changed(rx_cnt.rx_lpi_trans))
        else $error("idle rise not counted");
    chk_tx_fcs_count: assert property (
        tx_evt.done && tx_evt.fcs_err |=> tx_cnt.fcs_err == $past(tx_cnt.fcs_err) + 20'h1)
        else $error("bad check sequence not counted");
    chk_tx_bad_bytes: assert property (
        tx_evt.done && !tx_evt.good
        |=> tx_cnt.bad_bytes == $past(tx_cnt.bad_bytes) + {18'h0, $past(tx_evt.len)})
        else $error("errored bytes not summed");
    chk_excess_coll: assert property (
        tx_evt.done && tx_evt.coll_cnt >= `MSCNT_EXCESS_COLL
        |=> tx_cnt.excess_coll == $past(tx_cnt.excess_coll) + 20'h1)
        else $error("excess collision not counted");
    chk_flow_no_frames: assert property (
        tx_evt.done && tx_evt.flow_ctrl |=> $stable(tx_cnt.ucast_frm)
        && $stable(tx_cnt.bcast_frm) && $stable(tx_cnt.mcast_frm))
        else $error("flow control frame counted");
    chk_sz64_count: assert property (
        tx_ok && !tx_evt.partial && !tx_evt.flow_ctrl && tx_evt.len == `MSCNT_SZ_64
        |=> tx_cnt.sz_64 == $past(tx_cnt.sz_64) + 20'h1)
        else $error("64 byte frame not counted");
    chk_single_coll: assert property (
        tx_ok && tx_evt.coll_cnt == 5'h01
        |=> tx_cnt.single_coll == $past(tx_cnt.single_coll) + 20'h1)
        else $error("single collision not counted");
    // Main scenarios reached
    cov_rx_drop: cover property (rx_evt.done && rx_evt.filt_fail);
    cov_lpi_rise: cover property (energy_efficient_enable && $rose(phy_rx_lpi));
    cov_tx_flow: cover property (tx_ok && tx_evt.flow_ctrl);
endmodule
bind mscnt_stats mscnt_stats_chk u_chk (.mclk(mclk), .rst(rst),
    .energy_efficient_enable(energy_efficient_enable), .sleep_state_zero(sleep_state_zero),
    .sleep_state_three(sleep_state_three), .max_frame_size(max_frame_size), .rx_evt(rx_evt),
    .tx_evt(tx_evt), .tx_deferring(tx_deferring), .tx_defer_start(tx_defer_start),
    .phy_rx_lpi(phy_rx_lpi), .rx_cnt(rx_cnt), .tx_cnt(tx_cnt));

// >>> tb/mscnt_phy_model.sv
`timescale 1ns/1ns
module mscnt_phy_model (
    // Request from the bench
    input  wire logic lpi_cmd,
    // Idle level toward the MAC
    output logic      phy_rx_lpi
);
    // Skewed 3 ns off the clock: the level is unsynchronised, as a real PHY's is
    initial phy_rx_lpi = 1'b0;
    always @(lpi_cmd) begin
        phy_rx_lpi <= #3 lpi_cmd;
    end
endmodule

// >>> tb/mscnt_stats_tb.sv
`timescale 1ns/1ns
module mscnt_stats_tb;
    import mscnt_pkg::*;
    logic          mclk = 1'b0;
    logic          rst = 1'b1;
    logic          energy_efficient_enable = 1'b0;
    logic          sleep_state_zero = 1'b0;
    logic          sleep_state_three = 1'b0;
    logic [13:0]   max_frame_size = 14'h0004;
    mscnt_rx_type  rx_evt = '0;
    mscnt_tx_type  tx_evt = '0;
    logic          tx_deferring = 1'b0;
    logic          tx_defer_start = 1'b0;
    logic          lpi_cmd = 1'b0;
    logic          phy_rx_lpi;
    mscnt_rxc_type rx_cnt;
    mscnt_txc_type tx_cnt;
    int            fail_count = 0;
    int            tests_run = 0;

    // 125 MHz clock
    always #4 mclk = ~mclk;

    mscnt_phy_model phy (.lpi_cmd(lpi_cmd), .phy_rx_lpi(phy_rx_lpi));
    mscnt_stats dut (.mclk(mclk), .rst(rst), .energy_efficient_enable(energy_efficient_enable),
        .sleep_state_zero(sleep_state_zero), .sleep_state_three(sleep_state_three),
        .max_frame_size(max_frame_size), .rx_evt(rx_evt), .tx_evt(tx_evt),
        .tx_deferring(tx_deferring), .tx_defer_start(tx_defer_start), .phy_rx_lpi(phy_rx_lpi),
        .rx_cnt(rx_cnt), .tx_cnt(tx_cnt));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Events go out at the falling edge, back to back when called in a row
    task automatic rx_go(input logic [2:0] f, input logic [13:0] len);
        @(negedge mclk);
        rx_evt <= {1'b1, f, len};
    endtask
    task automatic tx_go(input logic [6:0] f, input logic [4:0] cc, input logic [1:0] ct,
                         input logic [13:0] len);
        @(negedge mclk);
        tx_evt <= {1'b1, f, cc, ct, len};
    endtask
    task automatic idle(input int n);
        @(negedge mclk);
        rx_evt.done <= 1'b0;
        tx_evt.done <= 1'b0;
        repeat (n) @(negedge mclk);
    endtask
    task automatic defer(input int n);
        tx_defer_start <= 1'b1;
        tx_deferring <= 1'b1;
        @(negedge mclk);
        tx_defer_start <= 1'b0;
        repeat (n) @(negedge mclk);
    endtask

    // Flags {good, filtered, overflow}; bounds and each drop reason
    task automatic t_rx_sizes();
        rx_go(3'b100, 14'h0200);
        rx_go(3'b100, 14'h03ff);
        rx_go(3'b100, 14'h0400);
        rx_go(3'b100, 14'h05ee);
        rx_go(3'b100, 14'h05ef);
        rx_go(3'b100, 14'h01ff);
        rx_go(3'b110, 14'h0258);
        rx_go(3'b101, 14'h0258);
        rx_go(3'b000, 14'h0258);
        idle(1);
        chk("rx_512_1023", 32'h2, rx_cnt.rx_512_1023);
        chk("rx_1024_1518", 32'h2, rx_cnt.rx_1024_1518);
        chk("rx_over_1518", 32'h1, rx_cnt.rx_over_1518);
        $display("t_rx_sizes done");
    endtask
    // 300 cycles of idle is 2.4 us, so two whole microseconds
    task automatic t_lpi();
        energy_efficient_enable <= 1'b1;
        sleep_state_zero <= 1'b1;
        idle(2);
        lpi_cmd <= 1'b1;
        idle(300);
        lpi_cmd <= 1'b0;
        idle(10);
        chk("rx_lpi_trans", 32'h1, rx_cnt.rx_lpi_trans);
        chk("rx_lpi_time", 32'h2, rx_cnt.rx_lpi_time);
        sleep_state_zero <= 1'b0;
        sleep_state_three <= 1'b1;
        lpi_cmd <= 1'b1;
        idle(20);
        lpi_cmd <= 1'b0;
        idle(10);
        chk("rx_lpi_trans", 32'h2, rx_cnt.rx_lpi_trans);
        energy_efficient_enable <= 1'b0;
        idle(2);
        chk("rx_lpi_trans", 32'h0, rx_cnt.rx_lpi_trans);
        chk("rx_lpi_time", 32'h0, rx_cnt.rx_lpi_time);
        $display("t_lpi done");
    endtask
    // Flags {good, fcs, carrier, late, flow, pause, partial}
    task automatic t_tx_errors();
        tx_go(7'b0100000, 5'h00, 2'h0, 14'h0064);
        tx_go(7'b0010000, 5'h00, 2'h0, 14'h0040);
        tx_go(7'b0001000, 5'h01, 2'h0, 14'h0080);
        tx_go(7'b0000000, 5'h10, 2'h0, 14'h0020);
        tx_go(7'b0000000, 5'h0f, 2'h0, 14'h0010);
        idle(1);
        chk("fcs_err", 32'h1, tx_cnt.fcs_err);
        chk("carrier_err", 32'h1, tx_cnt.carrier_err);
        chk("late_coll", 32'h1, tx_cnt.late_coll);
        chk("excess_coll", 32'h1, tx_cnt.excess_coll);
        chk("bad_bytes", 32'h154, tx_cnt.bad_bytes);
        chk("sz_64", 32'h0, tx_cnt.sz_64);
        $display("t_tx_errors done");
    endtask
    task automatic t_tx_good();
        tx_go(7'b1000000, 5'h00, 2'h0, 14'h0040);
        tx_go(7'b1000000, 5'h01, 2'h1, 14'h00c8);
        tx_go(7'b1000000, 5'h02, 2'h2, 14'h012c);
        tx_go(7'b1000110, 5'h00, 2'h2, 14'h0040);
        tx_go(7'b1000001, 5'h00, 2'h0, 14'h0064);
        idle(1);
        chk("ucast_frm", 32'h2, tx_cnt.ucast_frm);
        chk("mcast_frm", 32'h1, tx_cnt.mcast_frm);
        chk("bcast_frm", 32'h1, tx_cnt.bcast_frm);
        chk("ucast_bytes", 32'h40, tx_cnt.ucast_bytes);
        chk("bcast_bytes", 32'hc8, tx_cnt.bcast_bytes);
        chk("mcast_bytes", 32'h12c, tx_cnt.mcast_bytes);
        chk("multi_coll", 32'h1, tx_cnt.multi_coll);
        chk("single_coll", 32'h1, tx_cnt.single_coll);
        chk("pause_frm", 32'h1, tx_cnt.pause_frm);
        chk("sz_64", 32'h1, tx_cnt.sz_64);
        chk("sz_65_127", 32'h0, tx_cnt.sz_65_127);
        chk("sz_128_255", 32'h1, tx_cnt.sz_128_255);
        chk("sz_256_511", 32'h1, tx_cnt.sz_256_511);
        $display("t_tx_good done");
    endtask
    // Limit is (2*4+16)*8 = 192 bit times; two 121-cycle spells must not add up
    task automatic t_defer();
        defer(120);
        defer(120);
        tx_deferring <= 1'b0;
        tx_go(7'b1000000, 5'h00, 2'h0, 14'h0040);
        idle(1);
        chk("excess_defer", 32'h0, tx_cnt.excess_defer);
        defer(250);
        tx_deferring <= 1'b0;
        tx_go(7'b1000000, 5'h00, 2'h0, 14'h0040);
        idle(1);
        chk("excess_defer", 32'h1, tx_cnt.excess_defer);
        tx_go(7'b1000000, 5'h00, 2'h0, 14'h0040);
        idle(1);
        chk("excess_defer", 32'h1, tx_cnt.excess_defer);
        $display("t_defer done");
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        rst <= 1'b0;
        t_rx_sizes();
        t_lpi();
        t_tx_errors();
        t_tx_good();
        t_defer();
        stop_test();
    end
    // Tests need about 900 cycles; cut a hang well beyond that
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        stop_test();
    end
endmodule
